// File: hw/ictm_top.v
// Interrupt controller with four interval timers as sources.
// Assumes a same-clock load/store register port from the processor and
// external interrupt pins that are asynchronous to i_mclk.
// ============================================================
// Usage notes
// Register port: every read or write strobe is answered by o_bus_ready
// exactly one cycle later. There are no wait states and nothing is
// refused, so the processor may issue a strobe in every cycle.
// Read data stand for that single cycle and are zero at all other times.
// The zero lets several slaves share a read bus through a plain OR.
// Write-only and unmapped locations read as zero. Software therefore
// cannot read back an enable, mode, vector or preload value, and must
// keep its own copy of any value that it wants to modify later.
// Byte enables select the lanes that a write changes; timer writes ignore them. A partial write
// to a vector fills the unselected lanes with zero. The vector store has
// a single read port, which serves the priority select, so there is no
// old word to merge with. Vectors should be written as whole words.
// A partial write to the acknowledge register clears only the bits in
// its selected lanes; the other lanes count as written with zero.
//
// Interrupt timing: an event pulse at one edge sets its status bit at
// that edge. The request follows one edge later if the source is
// enabled, and the vector and the fast flag one edge after the request.
// The controller that takes the request should wait for that extra cycle
// before it uses the vector.
// An event that arrives in the cycle of its own acknowledge wins, so a
// second event is never lost; the status bit simply stays set.
// The lowest pending bit number has the highest priority. A later event
// on a lower bit therefore changes the vector while the request stands.
//
// External pins pass two flip-flops and are taken on their rising edge.
// A pulse must be longer than one clock cycle to be seen reliably.
// A pin that stays high sets its status bit once; acknowledging it
// does not set the bit again until the pin has fallen and risen.
//
// Interval timers count one event per clock cycle. The period is the
// preload plus two cycles: one to fetch the preload and one at zero.
// Writing the preload or the control register restarts the count from
// the preload, which keeps software timing simple at the cost of losing
// the part of the period that has already run.
// A one-shot timer clears its own enable after the lapse. It is started
// again only by a new write to its control register.
`timescale 1ns/10ps
`include "ictm_consts.vh"

module ictm_top #(
  parameter external_source_count = 16,
  parameter fast_mode_option      = 1,
  parameter vector_address_width  = 32,
  parameter timer_readback_option = 1
) (
  input  wire        i_mclk,
  input  wire        i_reset,
  input  wire [7:0]  i_bus_addr,
  input  wire [31:0] i_bus_wdata,
  input  wire [3:0]  i_bus_be,
  input  wire        i_bus_wr,
  input  wire        i_bus_rd,
  output reg  [31:0] o_bus_rdata,
  output reg         o_bus_ready,
  input  wire        i_uart_error,
  input  wire        i_uart_tx_done,
  input  wire        i_uart_rx_ready,
  input  wire [3:0]  i_fixed_timer_strobe,
  input  wire [15:0] i_external_interrupt_in,
  output reg         o_interrupt_request_out,
  output reg  [31:0] o_interrupt_vector_out,
  output reg         o_interrupt_fast
);

  // ============================================================
  // Source layout
  localparam [31:0] EXT_MASK =
    ((32'h1 << external_source_count) - 32'h1) << `ICTM_BIT_EXT0;
  localparam [31:0] SRC_MASK = EXT_MASK | `ICTM_INT_MASK;
  localparam [31:0] VEC_MASK = (vector_address_width >= 32) ?
    32'hfffffffc : (((32'h1 << vector_address_width) - 32'h1) & 32'hfffffffc);

  // Merges written byte lanes into an old word.
  function [31:0] merge_bytes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  be;
    integer      b;
    begin
      merge_bytes = old_word;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          merge_bytes[b*8 +: 8] = new_word[b*8 +: 8];
        end
      end
    end
  endfunction

  // Index of the lowest set bit, which has the highest priority.
  function [4:0] lowest_bit;
    input [31:0] vec;
    integer      n;
    begin
      lowest_bit = 5'h00;
      for (n = 31; n >= 0; n = n - 1) begin
        if (vec[n]) begin
          lowest_bit = n[4:0];
        end
      end
    end
  endfunction

  // ============================================================
  // Pin synchronisers and edge detection for external sources
  reg  [15:0] ext_meta_reg;
  reg  [15:0] ext_sync_reg;
  reg  [15:0] ext_last_reg;
  wire [15:0] ext_rise = ext_sync_reg & ~ext_last_reg;

  // Two flops before use, since the pins are asynchronous to i_mclk.
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ext_meta_reg <= 16'h0000;
      ext_sync_reg <= 16'h0000;
      ext_last_reg <= 16'h0000;
    end else begin
      ext_meta_reg <= i_external_interrupt_in;
      ext_sync_reg <= ext_meta_reg;
      ext_last_reg <= ext_sync_reg;
    end
  end

  // ============================================================
  // Address decode
  wire       hit_status  = (i_bus_addr == `ICTM_OFS_STATUS);
  wire       hit_pending = (i_bus_addr == `ICTM_OFS_PENDING);
  wire       hit_enable  = (i_bus_addr == `ICTM_OFS_ENABLE);
  wire       hit_ack     = (i_bus_addr == `ICTM_OFS_ACK);
  wire       hit_mode    = (i_bus_addr == `ICTM_OFS_MODE);
  wire       hit_vector  = (i_bus_addr[7] == 1'b1);
  wire [4:0] vec_index   = i_bus_addr[6:2];
  wire [1:0] tmr_index   = i_bus_addr[5:4];
  wire       hit_timer   = (i_bus_addr[7:6] == 2'b01);
  wire [3:0] tmr_slot    = i_bus_addr[3:0];

  // ============================================================
  // Interval timers
  wire [3:0]  tmr_lapse;
  wire [31:0] tmr_count [0:3];
  genvar      t;

  generate
    for (t = 0; t < `ICTM_NUM_TIMERS; t = t + 1) begin : g_timer
      ictm_interval_timer #(
        .READABLE (timer_readback_option)
      ) u_timer (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_load_we (i_bus_wr && hit_timer && tmr_index == t &&
                    tmr_slot == `ICTM_TSLOT_LOAD),
        .i_ctrl_we (i_bus_wr && hit_timer && tmr_index == t &&
                    tmr_slot == `ICTM_TSLOT_CTRL),
        .i_wdata   (i_bus_wdata),
        .o_count   (tmr_count[t]),
        .o_lapse   (tmr_lapse[t])
      );
    end
  endgenerate

  // ============================================================
  // Status, enable and mode registers
  reg  [31:0] status_reg;
  reg  [31:0] enable_reg;
  reg  [31:0] mode_reg;
  wire [31:0] events;
  wire [31:0] ack_bits;
  wire [31:0] pending;

  // Event vector in status bit order.
  assign events = ({ext_rise, 16'h0000} & EXT_MASK) |
                  {21'h000000, i_fixed_timer_strobe, tmr_lapse,
                   i_uart_rx_ready, i_uart_tx_done, i_uart_error};
  assign ack_bits = (i_bus_wr && hit_ack) ?
                    merge_bytes(32'h0, i_bus_wdata, i_bus_be) : 32'h0;
  assign pending  = status_reg & enable_reg;

  // A new event in the acknowledge cycle wins, so no event is lost.
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      status_reg <= 32'h00000000;
      enable_reg <= 32'h00000000;
      mode_reg   <= 32'h00000000;
    end else begin
      status_reg <= ((status_reg & ~ack_bits) | events) & SRC_MASK;
      if (i_bus_wr && hit_enable) begin
        enable_reg <= merge_bytes(enable_reg, i_bus_wdata, i_bus_be) &
                      SRC_MASK;
      end
      if (i_bus_wr && hit_mode && fast_mode_option == 1) begin
        mode_reg <= merge_bytes(mode_reg, i_bus_wdata, i_bus_be);
      end
    end
  end

  // ============================================================
  // Vector store
  wire [31:0] vec_old;
  wire        vec_allowed = SRC_MASK[vec_index];
  wire        vec_we      = i_bus_wr && hit_vector && vec_allowed &&
                            fast_mode_option == 1;
  wire [4:0]  sel_index   = lowest_bit(pending);
  wire [31:0] vec_rdata;

  // Byte lanes need the old word; a shadow of the last vector write would
  // not cover other words, so partial writes fill unwritten lanes with zero.
  assign vec_old = 32'h0;

  ictm_vector_mem #(
    .WIDTH (32)
  ) u_vectors (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_we    (vec_we),
    .i_waddr (vec_index),
    .i_wdata (merge_bytes(vec_old, i_bus_wdata, i_bus_be) & VEC_MASK),
    .i_raddr (sel_index),
    .o_rdata (vec_rdata)
  );

  // ============================================================
  // Interrupt outputs
  // The vector follows the selected source with two cycles of latency,
  // one through the memory read and one here; the request has one.
  reg [4:0] sel_last_reg;

  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_interrupt_request_out <= 1'b0;
      o_interrupt_vector_out  <= 32'h00000000;
      o_interrupt_fast        <= 1'b0;
      sel_last_reg            <= 5'h00;
    end else begin
      o_interrupt_request_out <= |pending;
      sel_last_reg            <= sel_index;
      if (fast_mode_option == 1) begin
        o_interrupt_vector_out <= vec_rdata;
        o_interrupt_fast       <= mode_reg[sel_last_reg];
      end else begin
        o_interrupt_vector_out <= 32'h00000000;
        o_interrupt_fast       <= 1'b0;
      end
    end
  end

  // ============================================================
  // Read data path
  reg [31:0] rdata_next;

  // Write-only and unmapped locations read as zero.
  always @* begin
    rdata_next = 32'h00000000;
    if (hit_status) begin
      rdata_next = status_reg;
    end else if (hit_pending) begin
      rdata_next = pending;
    end else if (hit_timer && tmr_slot == `ICTM_TSLOT_COUNT) begin
      rdata_next = tmr_count[tmr_index];
    end
  end

  // One-cycle answer for every access, reads sample at the taking edge.
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_bus_rdata <= 32'h00000000;
      o_bus_ready <= 1'b0;
    end else begin
      o_bus_ready <= i_bus_rd | i_bus_wr;
      o_bus_rdata <= i_bus_rd ? rdata_next : 32'h00000000;
    end
  end

endmodule // ictm_top

// File: hw/ictm_consts.vh
// Constants of the interrupt controller and interval timer block.
// Assumes byte addresses on the register port, relative to the block base.
`ifndef ICTM_CONSTS_VH
`define ICTM_CONSTS_VH

// ============================================================
// Register offsets (byte addresses)
`define ICTM_OFS_STATUS   8'h30
`define ICTM_OFS_PENDING  8'h34
`define ICTM_OFS_ENABLE   8'h38
`define ICTM_OFS_ACK      8'h3c
`define ICTM_OFS_MODE     8'h0c
`define ICTM_OFS_TIMER0   8'h40
`define ICTM_OFS_VECTOR0  8'h80
`define ICTM_TIMER_STRIDE 8'h10

// ============================================================
// Offsets inside one timer slot
`define ICTM_TSLOT_LOAD   4'h0
`define ICTM_TSLOT_COUNT  4'h4
`define ICTM_TSLOT_CTRL   4'h8

// ============================================================
// Field positions and reset values
`define ICTM_BIT_UART_ERR 0
`define ICTM_BIT_UART_TX  1
`define ICTM_BIT_UART_RX  2
`define ICTM_BIT_TIMER0   3
`define ICTM_BIT_FIXED0   7
`define ICTM_BIT_EXT0     16
`define ICTM_INT_MASK     32'h000007ff
`define ICTM_CTRL_EN      0
`define ICTM_CTRL_RELOAD  1
`define ICTM_VECTOR_RESET 32'h00000010
`define ICTM_NUM_TIMERS   4
`define ICTM_TIMER_WIDTH  32

`endif

// File: hw/ictm_vector_mem.v
// Holds the 32 interrupt vector words with a registered read port.
// Assumes writes are already filtered and masked by the controller.
`timescale 1ns/10ps
`include "ictm_consts.vh"

module ictm_vector_mem #(
  parameter WIDTH = 32
) (
  input  wire             i_mclk,
  input  wire             i_reset,
  input  wire             i_we,
  input  wire [4:0]       i_waddr,
  input  wire [WIDTH-1:0] i_wdata,
  input  wire [4:0]       i_raddr,
  output reg  [WIDTH-1:0] o_rdata
);

  // ============================================================
  // Storage
  reg [WIDTH-1:0] mem_reg [0:31];
  integer         k;

  // Every word resets, so a vector is defined before software writes it.
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      for (k = 0; k < 32; k = k + 1) begin
        mem_reg[k] <= `ICTM_VECTOR_RESET;
      end
      o_rdata <= `ICTM_VECTOR_RESET;
    end else begin
      if (i_we) begin
        mem_reg[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_reg[i_raddr];
    end
  end

endmodule // ictm_vector_mem

// File: hw/ictm_interval_timer.v
// One programmable interval timer: preload, counter and control.
// Assumes one count event per clock cycle and same-clock write strobes.
`timescale 1ns/10ps
`include "ictm_consts.vh"

module ictm_interval_timer #(
  parameter READABLE = 1
) (
  input  wire                         i_mclk,
  input  wire                         i_reset,
  input  wire                         i_load_we,
  input  wire                         i_ctrl_we,
  input  wire [`ICTM_TIMER_WIDTH-1:0] i_wdata,
  output wire [`ICTM_TIMER_WIDTH-1:0] o_count,
  output reg                          o_lapse
);

  // ============================================================
  // State
  reg [`ICTM_TIMER_WIDTH-1:0] load_reg;
  reg [`ICTM_TIMER_WIDTH-1:0] count_reg;
  reg                         en_reg;
  reg                         reload_reg;
  reg                         fetch_reg;

  // Counter is hidden when the readback option is off.
  assign o_count = (READABLE == 1) ? count_reg : {`ICTM_TIMER_WIDTH{1'b0}};

  // The fetch cycle after each lapse makes the period preload plus two.
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      load_reg   <= {`ICTM_TIMER_WIDTH{1'b0}};
      count_reg  <= {`ICTM_TIMER_WIDTH{1'b0}};
      en_reg     <= 1'b0;
      reload_reg <= 1'b0;
      fetch_reg  <= 1'b1;
      o_lapse    <= 1'b0;
    end else begin
      o_lapse <= 1'b0;
      if (i_load_we) begin
        load_reg  <= i_wdata;
        fetch_reg <= 1'b1;
      end
      if (i_ctrl_we) begin
        en_reg     <= i_wdata[`ICTM_CTRL_EN];
        reload_reg <= i_wdata[`ICTM_CTRL_RELOAD];
        fetch_reg  <= 1'b1;
      end else if (en_reg && !i_load_we) begin
        if (fetch_reg) begin
          count_reg <= load_reg;
          fetch_reg <= 1'b0;
        end else if (count_reg == {`ICTM_TIMER_WIDTH{1'b0}}) begin
          o_lapse   <= 1'b1;
          fetch_reg <= 1'b1;
          en_reg    <= reload_reg;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

endmodule // ictm_interval_timer

// File: verification/ictm_checker.sv
// Port-level checker for the interrupt controller and timer block.
// Assumes one clock i_mclk and an asynchronous active-high i_reset.
`timescale 1ns/10ps
// ==========================================================
// Checker
module ictm_checker (
  input wire        i_mclk,
  input wire        i_reset,
  input wire [7:0]  i_bus_addr,
  input wire [31:0] i_bus_wdata,
  input wire [3:0]  i_bus_be,
  input wire        i_bus_wr,
  input wire        i_bus_rd,
  input wire [31:0] o_bus_rdata,
  input wire        o_bus_ready,
  input wire        o_interrupt_request_out,
  input wire [31:0] o_interrupt_vector_out
);
  reg  [31:0] en_reg;
  wire [31:0] lane_mask;
  assign lane_mask = {{8{i_bus_be[3]}}, {8{i_bus_be[2]}},
                      {8{i_bus_be[1]}}, {8{i_bus_be[0]}}};
  // Shadow of the enable register; it is write-only, so masking can
  // only be judged at the pins by tracking the writes.
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset)
      en_reg <= 32'h0;
    else if (i_bus_wr && i_bus_addr == 8'h38)
      en_reg <= (en_reg & ~lane_mask) | (i_bus_wdata & lane_mask);
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  property p_ready;
    o_bus_ready == $past(i_bus_rd || i_bus_wr);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready does not follow the strobe");
  property p_rdata_idle;
    !o_bus_ready |-> o_bus_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero while idle");
  property p_irq_reset;
    $fell(i_reset) |-> !o_interrupt_request_out [*3];
  endproperty
  a_irq_reset: assert property (p_irq_reset)
    else $error("request high after reset");
  property p_irq_en;
    $rose(o_interrupt_request_out) |-> en_reg != 32'h0;
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("request with nothing enabled");
  property p_pend_mask;
    logic [31:0] e;
    (i_bus_rd && i_bus_addr == 8'h34, e = en_reg) |=>
      (o_bus_rdata & ~e) == 32'h0;
  endproperty
  a_pend_mask: assert property (p_pend_mask)
    else $error("pending shows a disabled bit");
  property p_resv_zero;
    i_bus_rd && i_bus_addr[7:3] == 5'h06 |=> o_bus_rdata[15:11] == 5'h0;
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved status bits set");
  property p_wo_read;
    i_bus_rd && (i_bus_addr == 8'h38 || i_bus_addr == 8'h3c) |=>
      o_bus_rdata == 32'h0;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("write-only register reads nonzero");
  property p_ack_clear;
    i_bus_wr && i_bus_addr == 8'h3c && i_bus_wdata == 32'hffffffff &&
      i_bus_be == 4'hf |-> ##[1:3] !o_interrupt_request_out;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("request stays after full acknowledge");
  property p_vec_low;
    $rose(o_interrupt_request_out) |=> o_interrupt_vector_out[1:0] == 2'h0;
  endproperty
  a_vec_low: assert property (p_vec_low)
    else $error("vector low bits not zero");
endmodule // ictm_checker

bind ictm_top ictm_checker i_chk (.i_mclk(i_mclk), .i_reset(i_reset),
  .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
  .i_bus_be(i_bus_be), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
  .o_bus_rdata(o_bus_rdata), .o_bus_ready(o_bus_ready),
  .o_interrupt_request_out(o_interrupt_request_out),
  .o_interrupt_vector_out(o_interrupt_vector_out));

// File: verification/ictm_cpu_model.sv
// Processor model that issues load/store accesses to the register port.
// Assumes a one-cycle ready answer; it waits at most four cycles.
`timescale 1ns/10ps
// ==========================================================
// Load/store master
module ictm_cpu_model (
  input  wire        i_mclk,
  input  wire        i_ready,
  input  wire [31:0] i_rdata,
  output reg  [7:0]  o_addr,
  output reg  [31:0] o_wdata,
  output reg  [3:0]  o_be,
  output reg         o_wr,
  output reg         o_rd
);
  // Quiet bus from time zero, so no strobe is seen during reset.
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_be = 4'hf;
    o_wr = 1'h0;
    o_rd = 1'h0;
  end
  // One strobe cycle; address and data held until ready, then inverted
  // so that a late sample of stale values cannot pass by luck.
  task xfer(input [7:0] a, input [31:0] d, input w,
            output [31:0] q, output ok);
    integer n;
    begin
      @(negedge i_mclk);
      o_addr = a;
      o_wdata = d;
      o_wr = w;
      o_rd = !w;
      ok = 1'h0;
      q = 32'h0;
      for (n = 0; n < 4 && !ok; n = n + 1) begin
        @(negedge i_mclk);
        o_wr = 1'h0;
        o_rd = 1'h0;
        ok = i_ready;
        q = i_rdata;
      end
      o_addr = ~a;
      o_wdata = ~d;
    end
  endtask
endmodule // ictm_cpu_model

// File: verification/tb_top.sv
// Self-checking bench for the interrupt controller and interval timers.
// Assumes the default build parameters of the block.
`timescale 1ns/10ps
// ==========================================================
// Bench
module tb_top;
  localparam PRE = 20;
  reg         mclk;
  reg         reset;
  reg  [6:0]  src;
  reg  [15:0] ext;
  wire [7:0]  addr;
  wire [31:0] wdata, rdata, vec;
  wire [3:0]  be;
  wire        wr, rd, ready, intr, fast;
  integer     fail_count, checks_done, cyc, t1, i;
  reg  [31:0] q1, q2;
  reg         ok;
  reg  [72:0] rows [0:10];
  ictm_top i_dut (.i_mclk(mclk), .i_reset(reset), .i_bus_addr(addr),
    .i_bus_wdata(wdata), .i_bus_be(be), .i_bus_wr(wr), .i_bus_rd(rd),
    .o_bus_rdata(rdata), .o_bus_ready(ready), .i_uart_error(src[0]),
    .i_uart_tx_done(src[1]), .i_uart_rx_ready(src[2]),
    .i_fixed_timer_strobe(src[6:3]), .i_external_interrupt_in(ext),
    .o_interrupt_request_out(intr), .o_interrupt_vector_out(vec),
    .o_interrupt_fast(fast));
  ictm_cpu_model i_cpu (.i_mclk(mclk), .i_ready(ready), .i_rdata(rdata),
    .o_addr(addr), .o_wdata(wdata), .o_be(be), .o_wr(wr), .o_rd(rd));
  // Free clock and a cycle count used to time the lapse period.
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  task give_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // A missing answer ends the run, since later steps would be meaningless.
  task bus(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
      i_cpu.xfer(a, d, w, q, ok);
      chk({31'h0, ok}, 32'h1);
      if (!ok)
        give_verdict;
    end
  endtask
  task wait_intr(input lvl);
    integer n;
    begin
      for (n = 0; n < 300 && intr !== lvl; n = n + 1)
        @(negedge mclk);
      chk({31'h0, intr}, {31'h0, lvl});
      if (intr !== lvl)
        give_verdict;
    end
  endtask
  task ev(input [6:0] v);
    begin
      @(negedge mclk);
      src = v;
      @(negedge mclk);
      src = 7'h0;
    end
  endtask
  initial begin
    {fail_count, checks_done, cyc} = 96'h0;
    {reset, src, ext} = {1'h1, 7'h0, 16'h0};
    rows[0] = {1'h1, 8'h0c, 32'h1, 32'h0};
    rows[1] = {1'h1, 8'h38, 32'h0, 32'h0};
    rows[2] = {1'h0, 8'h30, 32'h0, 32'h0};
    rows[3] = {1'h0, 8'h34, 32'h0, 32'h0};
    rows[4] = {1'h0, 8'h38, 32'h0, 32'h0};
    rows[5] = {1'h0, 8'h3c, 32'h0, 32'h0};
    rows[6] = {1'h0, 8'h0c, 32'h0, 32'h0};
    rows[7] = {1'h0, 8'h44, 32'h0, 32'h0};
    rows[8] = {1'h0, 8'h4c, 32'h0, 32'h0};
    rows[9] = {1'h0, 8'h80, 32'h0, 32'h0};
    rows[10] = {1'h0, 8'h00, 32'h0, 32'h0};
    repeat (10) @(negedge mclk);
    reset = 1'h0;
    for (i = 0; i < 11; i = i + 1) begin
      bus(rows[i][72], rows[i][71:64], rows[i][63:32], q1);
      if (!rows[i][72])
        chk(q1, rows[i][31:0]);
    end
    // Events on disabled sources: status fills, no request.
    ev(7'h7f);
    bus(0, 8'h30, 0, q1);
    chk(q1, 32'h787);
    bus(0, 8'h34, 0, q1);
    chk(q1, 32'h0);
    chk({31'h0, intr}, 32'h0);
    bus(1, 8'h38, 32'h3, q1);
    wait_intr(1);
    @(negedge mclk);
    chk(vec, 32'h10);
    chk({31'h0, fast}, 32'h1);
    bus(0, 8'h34, 0, q1);
    chk(q1, 32'h3);
    bus(1, 8'h3c, 32'h1, q1);
    bus(0, 8'h30, 0, q1);
    chk(q1, 32'h786);
    bus(1, 8'h3c, 32'hffffffff, q1);
    wait_intr(0);
    // External pins land at bit 16 upward.
    ext = 16'h8001;
    repeat (6) @(negedge mclk);
    ext = 16'h0;
    bus(0, 8'h30, 0, q1);
    chk(q1, 32'h80010000);
    bus(1, 8'h3c, 32'hffffffff, q1);
    // Interval timer 0 in reload mode, then stopped, then one-shot.
    bus(1, 8'h8c, 32'hffffffff, q1);
    bus(1, 8'h38, 32'h8, q1);
    bus(1, 8'h40, PRE, q1);
    bus(1, 8'h48, 32'h3, q1);
    wait_intr(1);
    t1 = cyc;
    @(negedge mclk);
    chk(vec, 32'hfffffffc);
    chk({31'h0, fast}, 32'h0);
    bus(1, 8'h3c, 32'h8, q1);
    wait_intr(0);
    wait_intr(1);
    chk(cyc - t1, PRE + 2);
    bus(1, 8'h48, 32'h0, q1);
    bus(0, 8'h44, 0, q1);
    bus(0, 8'h44, 0, q2);
    chk(q2, q1);
    chk({31'h0, q1 > PRE}, 32'h0);
    bus(1, 8'h3c, 32'h8, q1);
    bus(1, 8'h48, 32'h1, q1);
    wait_intr(1);
    bus(1, 8'h3c, 32'h8, q1);
    wait_intr(0);
    repeat (70) @(negedge mclk);
    chk({31'h0, intr}, 32'h0);
    // Reset in mid-run with a request standing.
    bus(1, 8'h38, 32'h1, q1);
    ev(7'h01);
    wait_intr(1);
    reset = 1'h1;
    repeat (2) @(negedge mclk);
    reset = 1'h0;
    bus(0, 8'h30, 0, q1);
    chk(q1, 32'h0);
    ev(7'h01);
    repeat (4) @(negedge mclk);
    chk({31'h0, intr}, 32'h0);
    give_verdict;
  end
endmodule // tb_top
